// file: lcd_regs_consts.svh
`ifndef LCD_REGS_CONSTS_SVH
`define LCD_REGS_CONSTS_SVH
// Direct register addresses
`define ADDR_FONT_BASE_LO 16'h8019
`define ADDR_FONT_BASE_HI 16'h801A
`define ADDR_PIX_SHIFT 16'h801B
`define ADDR_CURSOR_LO 16'h801C
`define ADDR_CURSOR_HI 16'h801D
`define ADDR_CURSOR_RD_LO 16'h801E
`define ADDR_CURSOR_RD_HI 16'h801F
`define ADDR_DEPTH 16'h8020
// Indirect command codes
`define CMD_FONT_BASE 8'h5C
`define CMD_PIX_SHIFT 8'h5A
`define CMD_CURSOR_WR 8'h46
`define CMD_CURSOR_RD 8'h47
`define CMD_DEPTH 8'h60
`define CMD_MEM_WR 8'h42
`define CMD_MEM_RD 8'h43
`define CMD_DIR_BASE 6'h13
// Field widths and reset values
`define PIX_SHIFT_MASK 8'h07
`define DEPTH_MASK 8'h03
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`endif

// file: lcd_regs_pkg.sv
package lcd_regs_pkg;
  typedef enum logic [1:0] {
    DIR_RIGHT = 2'b00,
    DIR_LEFT = 2'b01,
    DIR_UP = 2'b10,
    DIR_DOWN = 2'b11
  } step_dir_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FONT = 3'b001,
    ST_SHIFT = 3'b010,
    ST_CURSOR = 3'b011,
    ST_DEPTH = 3'b100,
    ST_MEM_WR = 3'b101,
    ST_MEM_RD = 3'b110,
    ST_CUR_RD = 3'b111
  } cmd_state_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic a0;
    logic [15:0] addr;
    logic [7:0] wdata;
  } host_req_t;
  typedef struct packed {
    logic text_l1;
    logic graph_l2;
    logic graph_l3;
    logic use_l3;
  } layer_cfg_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage

// file: glyph_addr.sv
`timescale 1ns/1ps
// Glyph start = code * height + font base, registered
module glyph_addr (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [7:0] char_code,
  input wire logic [4:0] char_height,
  input wire logic [15:0] font_base,
  output logic [15:0] glyph_start
);
  logic [15:0] next_glyph_start;
  logic [12:0] product;

  // Product fits in 13 bits for 8-bit code and 5-bit height
  always_comb begin
    // Widen before multiplying so the product keeps its upper bits
    product = 13'(char_code) * 13'(char_height);
    next_glyph_start = 16'(font_base + {3'h0, product});
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      glyph_start <= 16'h0000;
    end else begin
      glyph_start <= next_glyph_start;
    end
  end
endmodule

// file: lcd_regs.sv
`timescale 1ns/1ps
`include "lcd_regs_consts.svh"
module lcd_regs
  import lcd_regs_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Host access: direct when indirect_mode low, A0 command port otherwise
  input wire lcd_regs_pkg::host_req_t host_req,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  output logic host_refused,
  // Mode and settings from the surrounding unit
  input wire logic indirect_mode,
  input wire logic first_layer_text,
  input wire logic [1:0] cursor_step_direction,
  input wire logic [15:0] address_pitch,
  input wire logic [7:0] glyph_code,
  input wire logic [4:0] glyph_height,
  // Display memory port
  output lcd_regs_pkg::mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  // Settings to the rest of the unit
  output logic [15:0] font_base,
  output logic [2:0] pixel_shift,
  output logic [1:0] pixel_depth,
  output logic [15:0] cursor_addr,
  output logic [15:0] glyph_start,
  output lcd_regs_pkg::layer_cfg_t layer_cfg
);
  import lcd_regs_pkg::*;

  typedef struct packed {
    logic [7:0] font_lo;
    logic [7:0] font_hi;
    logic [7:0] shift;
    logic [7:0] depth;
    logic [15:0] cursor;
    cmd_state_t state;
    logic [1:0] pcount;
    logic [7:0] rdata;
    logic rvalid;
    logic refused;
    mem_req_t mem;
    layer_cfg_t layers;
  } state_t;

  state_t r;
  state_t next_r;
  logic [15:0] stepped;
  logic cmd_wr;
  logic par_wr;
  logic par_rd;
  logic dir_wr;
  logic mem_access;

  // Cursor after one automatic step, direction from outside
  always_comb begin
    case (step_dir_t'(cursor_step_direction))
      DIR_RIGHT: stepped = 16'(r.cursor + 16'h0001);
      DIR_LEFT: stepped = 16'(r.cursor - 16'h0001);
      DIR_UP: stepped = 16'(r.cursor - address_pitch);
      default: stepped = 16'(r.cursor + address_pitch);
    endcase
  end

  // Indirect port decode: A0 high write is a command
  assign cmd_wr = host_req.sel & host_req.wr & host_req.a0 & indirect_mode;
  assign par_wr = host_req.sel & host_req.wr & ~host_req.a0 & indirect_mode;
  assign par_rd = host_req.sel & ~host_req.wr & host_req.a0 & indirect_mode;
  // Direction commands 4Ch-4Fh are decoded elsewhere; here they keep the state and only restart pcount
  assign dir_wr = cmd_wr && host_req.wdata[7:2] == `CMD_DIR_BASE;

  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.refused = 1'b0;
    next_r.mem.req = 1'b0;
    mem_access = 1'b0;
    // Layer usage: the later layers never carry text
    next_r.layers.text_l1 = first_layer_text;
    next_r.layers.graph_l2 = 1'b1;
    next_r.layers.graph_l3 = 1'b1;
    next_r.layers.use_l3 = ~first_layer_text;
    if (host_req.sel && !indirect_mode) begin
      // Direct access; memory reads below 8000h are refused in indirect only
      if (host_req.addr[15] == 1'b0) begin
        next_r.mem.req = 1'b1;
        next_r.mem.wr = host_req.wr;
        next_r.mem.addr = host_req.addr;
        next_r.mem.wdata = host_req.wdata;
      end else if (host_req.wr) begin
        if (host_req.addr == `ADDR_FONT_BASE_LO) begin
          next_r.font_lo = host_req.wdata;
        end else if (host_req.addr == `ADDR_FONT_BASE_HI) begin
          next_r.font_hi = host_req.wdata;
        end else if (host_req.addr == `ADDR_PIX_SHIFT) begin
          next_r.shift = host_req.wdata & `PIX_SHIFT_MASK;
        end else if (host_req.addr == `ADDR_CURSOR_LO) begin
          next_r.cursor[7:0] = host_req.wdata;
        end else if (host_req.addr == `ADDR_CURSOR_HI) begin
          next_r.cursor[15:8] = host_req.wdata;
        end else if (host_req.addr == `ADDR_DEPTH) begin
          next_r.depth = host_req.wdata & `DEPTH_MASK;
        end
      end else begin
        next_r.rvalid = 1'b1;
        if (host_req.addr == `ADDR_FONT_BASE_LO) begin
          next_r.rdata = r.font_lo;
        end else if (host_req.addr == `ADDR_FONT_BASE_HI) begin
          next_r.rdata = r.font_hi;
        end else if (host_req.addr == `ADDR_PIX_SHIFT) begin
          next_r.rdata = r.shift;
        end else if (host_req.addr == `ADDR_CURSOR_LO ||
                     host_req.addr == `ADDR_CURSOR_RD_LO) begin
          next_r.rdata = r.cursor[7:0];
        end else if (host_req.addr == `ADDR_CURSOR_HI ||
                     host_req.addr == `ADDR_CURSOR_RD_HI) begin
          next_r.rdata = r.cursor[15:8];
        end else if (host_req.addr == `ADDR_DEPTH) begin
          next_r.rdata = r.depth;
        end else begin
          next_r.rdata = 8'h00;
        end
      end
    end else if (host_req.sel && indirect_mode && !host_req.a0 &&
                 host_req.addr[15] == 1'b0 && !par_wr) begin
      // Direct memory read attempt while indirect
      next_r.refused = 1'b1;
    end else if (cmd_wr) begin
      // New command always restarts parameter counting
      next_r.pcount = 2'd0;
      if (host_req.wdata == `CMD_FONT_BASE) begin
        next_r.state = ST_FONT;
      end else if (host_req.wdata == `CMD_PIX_SHIFT) begin
        next_r.state = ST_SHIFT;
      end else if (host_req.wdata == `CMD_CURSOR_WR) begin
        next_r.state = ST_CURSOR;
      end else if (host_req.wdata == `CMD_DEPTH) begin
        next_r.state = ST_DEPTH;
      end else if (host_req.wdata == `CMD_MEM_WR) begin
        next_r.state = ST_MEM_WR;
      end else if (host_req.wdata == `CMD_MEM_RD) begin
        next_r.state = ST_MEM_RD;
      end else if (host_req.wdata == `CMD_CURSOR_RD) begin
        next_r.state = ST_CUR_RD;
      end else if (!dir_wr) begin
        next_r.state = ST_IDLE;
      end
    end else if (par_wr) begin
      // Parameter bytes, font base pair first
      case (r.state)
        ST_FONT: begin
          if (r.pcount == 2'd0) begin
            next_r.font_lo = host_req.wdata;
            next_r.pcount = 2'd1;
          end else if (r.pcount == 2'd1) begin
            next_r.font_hi = host_req.wdata;
            next_r.pcount = 2'd2;
          end
        end
        ST_SHIFT: begin
          next_r.shift = host_req.wdata & `PIX_SHIFT_MASK;
        end
        ST_CURSOR: begin
          if (r.pcount == 2'd0) begin
            next_r.cursor[7:0] = host_req.wdata;
            next_r.pcount = 2'd1;
          end else if (r.pcount == 2'd1) begin
            next_r.cursor[15:8] = host_req.wdata;
            next_r.pcount = 2'd2;
          end
        end
        ST_DEPTH: begin
          next_r.depth = host_req.wdata & `DEPTH_MASK;
        end
        ST_MEM_WR: begin
          mem_access = 1'b1;
          next_r.mem.req = 1'b1;
          next_r.mem.wr = 1'b1;
          next_r.mem.addr = r.cursor;
          next_r.mem.wdata = host_req.wdata;
        end
        default: begin
          next_r.pcount = r.pcount;
        end
      endcase
    end else if (par_rd) begin
      case (r.state)
        ST_CUR_RD: begin
          // Low byte first, then high, then stays high
          next_r.rvalid = 1'b1;
          if (r.pcount == 2'd0) begin
            next_r.rdata = r.cursor[7:0];
            next_r.pcount = 2'd1;
          end else begin
            next_r.rdata = r.cursor[15:8];
          end
        end
        ST_MEM_RD: begin
          mem_access = 1'b1;
          next_r.mem.req = 1'b1;
          next_r.mem.wr = 1'b0;
          next_r.mem.addr = r.cursor;
        end
        default: begin
          next_r.rvalid = 1'b1;
          next_r.rdata = 8'h00;
        end
      endcase
    end
    // Auto step; scroll settings never touch the cursor
    if (mem_access) begin
      next_r.cursor = stepped;
    end
    // Memory read data returns to the host
    if (mem_rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = mem_rdata;
    end
  end

  // All state but glyph_start in one register; everything clears on reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  glyph_addr u_glyph (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .char_code(glyph_code),
    .char_height(glyph_height),
    .font_base({r.font_hi, r.font_lo}),
    .glyph_start(glyph_start)
  );

  // Outputs straight from state; shift is global, not per layer
  assign host_rdata = r.rdata;
  assign host_rvalid = r.rvalid;
  assign host_refused = r.refused;
  assign mem_req = r.mem;
  assign font_base = {r.font_hi, r.font_lo};
  assign pixel_shift = r.shift[2:0];
  assign pixel_depth = r.depth[1:0];
  assign cursor_addr = r.cursor;
  assign layer_cfg = r.layers;
endmodule

// file: lcd_regs_properties.sv
`timescale 1ns/1ps
`include "lcd_regs_consts.svh"
module lcd_regs_properties (
  // Clock, reset and host side
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire lcd_regs_pkg::host_req_t host_req,
  input wire logic [7:0] host_rdata,
  input wire logic host_rvalid,
  input wire logic host_refused,
  input wire logic indirect_mode,
  input wire logic first_layer_text,
  input wire logic [1:0] cursor_step_direction,
  input wire logic [15:0] address_pitch,
  input wire logic [7:0] glyph_code,
  input wire logic [4:0] glyph_height,
  // Memory side and settings
  input wire lcd_regs_pkg::mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic [15:0] font_base,
  input wire logic [2:0] pixel_shift,
  input wire logic [1:0] pixel_depth,
  input wire logic [15:0] cursor_addr,
  input wire logic [15:0] glyph_start,
  input wire lcd_regs_pkg::layer_cfg_t layer_cfg
);
  import lcd_regs_pkg::*;
  logic [15:0] step;
  // Expected cursor move for the current direction
  assign step = cursor_step_direction == 2'h0 ? 16'h0001 :
    cursor_step_direction == 2'h1 ? 16'hFFFF :
    cursor_step_direction == 2'h2 ? -address_pitch : address_pitch;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Parameter byte of an indirect command
  sequence s_param;
    host_req.sel && !host_req.a0 && host_req.wr && indirect_mode;
  endsequence
  sequence s_cur_wr;
    host_req.sel && host_req.a0 && host_req.wr && indirect_mode &&
      host_req.wdata == `CMD_CURSOR_WR ##1 s_param ##1 s_param;
  endsequence
  AST_CUR_WR: assert property (s_cur_wr |=>
    cursor_addr == {$past(host_req.wdata), $past(host_req.wdata, 2)})
    else $error("cursor write bytes not loaded");
  AST_GLYPH: assert property ($past(arst_n) |-> glyph_start ==
    $past(glyph_code) * $past(glyph_height) + $past(font_base))
    else $error("glyph start wrong");
  AST_LAYER: assert property ($past(arst_n) |-> layer_cfg ==
    {$past(first_layer_text), 2'b11, !$past(first_layer_text)})
    else $error("layer usage wrong");
  AST_CUR_HOLD: assert property (
    $changed(cursor_addr) |-> $past(host_req.sel))
    else $error("cursor moved without request");
  AST_MEM_ADDR: assert property (
    mem_req.req && $past(indirect_mode) |-> mem_req.addr == $past(cursor_addr))
    else $error("memory access off cursor");
  AST_STEP: assert property (mem_req.req && $past(indirect_mode) |->
    cursor_addr == $past(cursor_addr) + $past(step))
    else $error("cursor step wrong");
  AST_REFUSE: assert property (host_req.sel && !host_req.wr &&
    !host_req.a0 && indirect_mode && host_req.addr < 16'h8000
    |=> host_refused && !mem_req.req) else $error("direct access not refused");
  AST_RD_FWD: assert property (mem_rvalid |=>
    host_rvalid && host_rdata == $past(mem_rdata))
    else $error("memory data not forwarded");
  AST_SHIFT: assert property (host_req.sel && host_req.wr &&
    !indirect_mode && host_req.addr == `ADDR_PIX_SHIFT |=>
    {5'h00, pixel_shift} == ($past(host_req.wdata) & 8'h07))
    else $error("pixel shift field wrong");
endmodule
bind lcd_regs lcd_regs_properties u_props (.clk_sys, .arst_n, .host_req,
  .host_rdata, .host_rvalid, .host_refused, .indirect_mode,
  .first_layer_text, .cursor_step_direction, .address_pitch, .glyph_code,
  .glyph_height, .mem_req, .mem_rdata, .mem_rvalid, .font_base,
  .pixel_shift, .pixel_depth, .cursor_addr, .glyph_start, .layer_cfg);

// file: mem_model.sv
`timescale 1ns/1ps
module mem_model (
  // Clock, reset and pacing
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic slow,
  // Display memory port
  input wire lcd_regs_pkg::mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid
);
  import lcd_regs_pkg::*;
  logic [7:0] store [256];
  logic [7:0] pend;
  logic [2:0] due;
  // Reads answer after one or three cycles; idle data toggles so stale
  // bytes never pass for a match
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      due <= 3'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_rvalid <= due[0];
      mem_rdata <= due[0] ? pend : ~mem_rdata;
      due <= due >> 1;
      if (mem_req.req && mem_req.wr) store[mem_req.addr[7:0]] <= mem_req.wdata;
      if (mem_req.req && !mem_req.wr) begin
        pend <= store[mem_req.addr[7:0]];
        due <= slow ? 3'h4 : 3'h1;
      end
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "lcd_regs_consts.svh"
module testbench;
  import lcd_regs_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  host_req_t host_req = '0;
  logic indirect_mode = 1'b0;
  logic first_layer_text = 1'b0;
  logic [1:0] cursor_step_direction = 2'h0;
  logic [15:0] address_pitch = 16'h0028;
  logic [7:0] glyph_code = 8'h80;
  logic [4:0] glyph_height = 5'h08;
  logic slow = 1'b0;
  logic [7:0] host_rdata, mem_rdata, rd;
  logic host_rvalid, host_refused, mem_rvalid;
  mem_req_t mem_req;
  logic [15:0] font_base, cursor_addr, glyph_start;
  logic [2:0] pixel_shift;
  logic [1:0] pixel_depth;
  layer_cfg_t layer_cfg;
  int failures = 0;
  int samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  lcd_regs u_dut (.clk_sys, .arst_n, .host_req, .host_rdata, .host_rvalid,
    .host_refused, .indirect_mode, .first_layer_text, .cursor_step_direction,
    .address_pitch, .glyph_code, .glyph_height, .mem_req, .mem_rdata,
    .mem_rvalid, .font_base, .pixel_shift, .pixel_depth, .cursor_addr,
    .glyph_start, .layer_cfg);
  mem_model u_mem (.clk_sys, .arst_n, .slow, .mem_req, .mem_rdata,
    .mem_rvalid);
  task automatic complete_run;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held over one rising edge; sel stays up for back to back use
  task automatic hreq(input logic a0, input logic wr, input logic [15:0] a,
      input logic [7:0] d);
    host_req = '{1'b1, wr, a0, a, d};
    @(negedge clk_sys);
  endtask
  task automatic idle;
    host_req.sel = 1'b0;
    @(negedge clk_sys);
  endtask
  // Read and wait a bounded time for the data pulse
  task automatic rdx(input logic a0, input logic [15:0] a);
    int i;
    hreq(a0, 1'b0, a, 8'h00);
    host_req.sel = 1'b0;
    for (i = 0; i < 8 && host_rvalid !== 1'b1; i++) @(negedge clk_sys);
    if (i == 8) begin
      failures++;
      complete_run();
    end
    rd = host_rdata;
    @(negedge clk_sys);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    chk(cursor_addr, 16'h0000);
    chk(font_base, 16'h0000);
    hreq(1'b0, 1'b1, `ADDR_FONT_BASE_HI, 8'h60);
    // Depth is 1 bpp here; row pitch is set up by the wider unit
    hreq(1'b0, 1'b1, `ADDR_PIX_SHIFT, 8'hFF);
    hreq(1'b0, 1'b1, `ADDR_CURSOR_RD_LO, 8'hAA);
    hreq(1'b0, 1'b1, 16'h0010, 8'hA5);
    rdx(1'b0, `ADDR_FONT_BASE_HI);
    chk(rd, 8'h60);
    chk(glyph_start, 16'h6400);
    rdx(1'b0, `ADDR_PIX_SHIFT);
    chk(rd, 8'h07);
    rdx(1'b0, `ADDR_CURSOR_RD_LO);
    chk(rd, 8'h00);
    rdx(1'b0, 16'h8021);
    chk(rd, 8'h00);
    rdx(1'b0, 16'h0010);
    chk(rd, 8'hA5);
    // Shift back to zero before leaving 1 bpp
    hreq(1'b0, 1'b1, `ADDR_PIX_SHIFT, 8'h00);
    // Every depth code, with stray upper bits set
    for (int v = 0; v < 4; v++) begin
      hreq(1'b0, 1'b1, `ADDR_DEPTH, 8'hFC | 8'(v));
      rdx(1'b0, `ADDR_DEPTH);
      chk(rd, 8'(v));
    end
    // Indirect commands; depth back to 1 bpp before any shift
    indirect_mode = 1'b1;
    first_layer_text = 1'b1;
    hreq(1'b1, 1'b1, 16'h0000, `CMD_FONT_BASE);
    hreq(1'b0, 1'b1, 16'h0000, 8'h34);
    hreq(1'b0, 1'b1, 16'h0000, 8'h12);
    hreq(1'b1, 1'b1, 16'h0000, `CMD_DEPTH);
    hreq(1'b0, 1'b1, 16'h0000, 8'h00);
    hreq(1'b1, 1'b1, 16'h0000, `CMD_PIX_SHIFT);
    hreq(1'b0, 1'b1, 16'h0000, 8'h05);
    hreq(1'b1, 1'b1, 16'h0000, `CMD_CURSOR_WR);
    hreq(1'b0, 1'b1, 16'h0000, 8'h20);
    hreq(1'b0, 1'b1, 16'h0000, 8'h00);
    hreq(1'b1, 1'b1, 16'h0000, `CMD_MEM_WR);
    chk(font_base, 16'h1234);
    chk(pixel_shift, 3'h5);
    chk(pixel_depth, 2'h0);
    chk(cursor_addr, 16'h0020);
    // Writes at 0020, 0021, 0020, FFF8 stepping in each direction
    for (int d = 0; d < 4; d++) begin
      cursor_step_direction = 2'(d);
      hreq(1'b0, 1'b1, 16'h0000, 8'h50 + 8'(d));
    end
    idle();
    chk(cursor_addr, 16'h0020);
    hreq(1'b1, 1'b1, 16'h0000, `CMD_CURSOR_RD);
    rdx(1'b1, 16'h0000);
    chk(rd, 8'h20);
    rdx(1'b1, 16'h0000);
    chk(rd, 8'h00);
    // Slow memory answers through the cursor
    cursor_step_direction = 2'h0;
    slow = 1'b1;
    hreq(1'b1, 1'b1, 16'h0000, `CMD_MEM_RD);
    rdx(1'b1, 16'h0000);
    chk(rd, 8'h52);
    rdx(1'b1, 16'h0000);
    chk(rd, 8'h51);
    hreq(1'b0, 1'b0, 16'h0010, 8'h00);
    host_req.sel = 1'b0;
    chk(host_refused, 1'b1);
    @(negedge clk_sys);
    indirect_mode = 1'b0;
    first_layer_text = 1'b0;
    rdx(1'b0, `ADDR_CURSOR_RD_LO);
    chk(rd, 8'h22);
    complete_run();
  end
endmodule
